// ===== ssd_top.sv
// Top of the dual axis safe stop delay unit: pin sync, selector capture,
// delay table, fault gathering and indicator drive.
// Assumes all pin inputs are asynchronous and i_rstn is the power-up reset.
`timescale 1ns/100ps
`include "ssd_consts.svh"

module ssd_top #(
    parameter int P_TICK_MS  = `SSD_TICK_MS,
    parameter int P_TICK_CYC = `SSD_TICK_MS * `SSD_CLK_KHZ
) (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_ce,
    input  wire ssd_pkg::ssd_sel_t i_delay_selector_first,
    input  wire ssd_pkg::ssd_sel_t i_delay_selector_second,
    input  wire logic              i_shutoff_channel_one_a,
    input  wire logic              i_shutoff_channel_two_a,
    input  wire logic              i_shutoff_release_input_a,
    input  wire logic              i_torque_off_feedback_a,
    input  wire logic              i_shutoff_channel_one_b,
    input  wire logic              i_shutoff_channel_two_b,
    input  wire logic              i_shutoff_release_input_b,
    input  wire logic              i_torque_off_feedback_b,
    output logic                   o_safety_output_one_a,
    output logic                   o_safety_output_two_a,
    output logic                   o_safety_output_one_b,
    output logic                   o_safety_output_two_b,
    output logic                   o_led_release_a,
    output logic                   o_led_channel_one_a,
    output logic                   o_led_channel_two_a,
    output logic                   o_led_sto_a,
    output logic                   o_led_out_one_a,
    output logic                   o_led_out_two_a,
    output logic                   o_led_fault_a,
    output logic                   o_led_release_b,
    output logic                   o_led_channel_one_b,
    output logic                   o_led_channel_two_b,
    output logic                   o_led_sto_b,
    output logic                   o_led_out_one_b,
    output logic                   o_led_out_two_b,
    output logic                   o_led_fault_b,
    output logic                   o_selector_match_indicator,
    output logic                   o_led_power
);
    import ssd_pkg::*;

    localparam int NPIN = 8;

    // ============================================================
    // Delay figures in ticks, derived from ms and the tick period
    localparam ssd_dly_t D_0   = ssd_dly_t'(`SSD_DLY_0_MS    / P_TICK_MS);
    localparam ssd_dly_t D_1P4 = ssd_dly_t'(`SSD_DLY_1P4_MS  / P_TICK_MS);
    localparam ssd_dly_t D_2P8 = ssd_dly_t'(`SSD_DLY_2P8_MS  / P_TICK_MS);
    localparam ssd_dly_t D_5P6 = ssd_dly_t'(`SSD_DLY_5P6_MS  / P_TICK_MS);
    localparam ssd_dly_t D_9P8 = ssd_dly_t'(`SSD_DLY_9P8_MS  / P_TICK_MS);
    localparam ssd_dly_t D_308 = ssd_dly_t'(`SSD_DLY_30P8_MS / P_TICK_MS);
    localparam logic [`SSD_TICK_W-1:0] TICK_LAST =
        `SSD_TICK_W'(P_TICK_CYC - 1);

    logic [NPIN-1:0]          pin_raw;
    logic [NPIN-1:0]          pin_s1_q;
    logic [NPIN-1:0]          pin_s2_q;
    ssd_sel_t                 sel1_s1_q;
    ssd_sel_t                 sel1_s2_q;
    ssd_sel_t                 sel2_s1_q;
    ssd_sel_t                 sel2_s2_q;
    ssd_sel_t                 sel1_q;
    ssd_sel_t                 sel2_q;
    logic                     cap_done_q;
    logic [1:0]               settle_q;
    logic [`SSD_TICK_W-1:0]   pre_q;
    logic                     tick_q;
    logic                     sel_err_q;
    ssd_dly_t                 dly_a;
    ssd_dly_t                 dly_b;
    logic                     hold;
    logic                     err_a;
    logic                     err_b;
    ssd_state_e               st_a;
    ssd_state_e               st_b;

    // ============================================================
    // Two-flop synchronisers for every pin input
    assign pin_raw = {i_shutoff_channel_one_a, i_shutoff_channel_two_a,
                      i_shutoff_release_input_a, i_torque_off_feedback_a,
                      i_shutoff_channel_one_b, i_shutoff_channel_two_b,
                      i_shutoff_release_input_b, i_torque_off_feedback_b};

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pin_s1_q  <= '0;
            pin_s2_q  <= '0;
            sel1_s1_q <= '0;
            sel1_s2_q <= '0;
            sel2_s1_q <= '0;
            sel2_s2_q <= '0;
        end else if (i_ce) begin
            pin_s1_q  <= pin_raw;
            pin_s2_q  <= pin_s1_q;
            sel1_s1_q <= i_delay_selector_first;
            sel1_s2_q <= sel1_s1_q;
            sel2_s1_q <= i_delay_selector_second;
            sel2_s2_q <= sel2_s1_q;
        end
    end

    // ============================================================
    // Selector capture once after reset release; later moves are ignored
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            settle_q   <= 2'h0;
            cap_done_q <= 1'b0;
            sel1_q     <= '0;
            sel2_q     <= '0;
        end else if (i_ce && !cap_done_q) begin
            if (settle_q == `SSD_SETTLE_CYC) begin
                sel1_q     <= sel1_s2_q;
                sel2_q     <= sel2_s2_q;
                cap_done_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    // Mismatch is checked on the captured codes only
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sel_err_q <= 1'b0;
        end else if (i_ce && cap_done_q && sel1_q != sel2_q) begin
            sel_err_q <= 1'b1;
        end
    end

    // ============================================================
    // Delay table; equal codes are required, so the first one steers
    always_comb begin
        dly_a = D_0;
        dly_b = D_0;
        case (sel1_q)
            4'h0: begin dly_a = D_0;   dly_b = D_0;   end
            4'h1: begin dly_a = D_0;   dly_b = D_1P4; end
            4'h2: begin dly_a = D_0;   dly_b = D_2P8; end
            4'h3: begin dly_a = D_0;   dly_b = D_9P8; end
            4'h4: begin dly_a = D_0;   dly_b = D_308; end
            4'h5: begin dly_a = D_1P4; dly_b = D_2P8; end
            4'h6: begin dly_a = D_1P4; dly_b = D_9P8; end
            4'h7: begin dly_a = D_1P4; dly_b = D_308; end
            4'h8: begin dly_a = D_2P8; dly_b = D_2P8; end
            4'h9: begin dly_a = D_2P8; dly_b = D_9P8; end
            4'hA: begin dly_a = D_2P8; dly_b = D_308; end
            4'hB: begin dly_a = D_5P6; dly_b = D_9P8; end
            4'hC: begin dly_a = D_5P6; dly_b = D_308; end
            4'hD: begin dly_a = D_9P8; dly_b = D_9P8; end
            4'hE: begin dly_a = D_9P8; dly_b = D_308; end
            4'hF: begin dly_a = D_308; dly_b = D_308; end
            default: begin dly_a = D_308; dly_b = D_308; end
        endcase
    end

    // ============================================================
    // Time base: one-cycle tick every P_TICK_CYC clocks
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end else if (i_ce) begin
            tick_q <= (pre_q == TICK_LAST);
            pre_q  <= (pre_q == TICK_LAST) ? '0 : pre_q + 1'b1;
        end
    end

    // Any fault stops both axes; no release until capture is complete
    assign hold = sel_err_q | err_a | err_b | ~cap_done_q;

    // ============================================================
    // Axis instances; channel inputs assume the same signal on both
    ssd_axis u_axis_a (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_ce    (i_ce),
        .i_tick  (tick_q),
        .i_dly   (dly_a),
        .i_ch1   (pin_s2_q[7]),
        .i_ch2   (pin_s2_q[6]),
        .i_rel   (pin_s2_q[5]),
        .i_tof   (pin_s2_q[4]),
        .i_hold  (hold),
        .o_state (st_a),
        .o_err   (err_a)
    );

    ssd_axis u_axis_b (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_ce    (i_ce),
        .i_tick  (tick_q),
        .i_dly   (dly_b),
        .i_ch1   (pin_s2_q[3]),
        .i_ch2   (pin_s2_q[2]),
        .i_rel   (pin_s2_q[1]),
        .i_tof   (pin_s2_q[0]),
        .i_hold  (hold),
        .o_state (st_b),
        .o_err   (err_b)
    );

    // ============================================================
    // Safety outputs: closed (1) drives, open (0) is STO; pairs identical
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_safety_output_one_a <= 1'b0;
            o_safety_output_two_a <= 1'b0;
            o_safety_output_one_b <= 1'b0;
            o_safety_output_two_b <= 1'b0;
        end else if (i_ce) begin
            o_safety_output_one_a <= ~st_a[2] & ~hold;
            o_safety_output_two_a <= ~st_a[2] & ~hold;
            o_safety_output_one_b <= ~st_b[2] & ~hold;
            o_safety_output_two_b <= ~st_b[2] & ~hold;
        end
    end

    // ============================================================
    // Per-axis indicators; a forced stop lights STO with the outputs
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_led_release_a     <= 1'b0;
            o_led_channel_one_a <= 1'b0;
            o_led_channel_two_a <= 1'b0;
            o_led_sto_a         <= 1'b0;
            o_led_out_one_a     <= 1'b0;
            o_led_out_two_a     <= 1'b0;
            o_led_release_b     <= 1'b0;
            o_led_channel_one_b <= 1'b0;
            o_led_channel_two_b <= 1'b0;
            o_led_sto_b         <= 1'b0;
            o_led_out_one_b     <= 1'b0;
            o_led_out_two_b     <= 1'b0;
        end else if (i_ce) begin
            o_led_release_a     <= pin_s2_q[5];
            o_led_channel_one_a <= ~pin_s2_q[7];
            o_led_channel_two_a <= ~pin_s2_q[6];
            o_led_sto_a         <= st_a[2] | hold;
            o_led_out_one_a     <= ~o_safety_output_one_a;
            o_led_out_two_a     <= ~o_safety_output_two_a;
            o_led_release_b     <= pin_s2_q[1];
            o_led_channel_one_b <= ~pin_s2_q[3];
            o_led_channel_two_b <= ~pin_s2_q[2];
            o_led_sto_b         <= st_b[2] | hold;
            o_led_out_one_b     <= ~o_safety_output_one_b;
            o_led_out_two_b     <= ~o_safety_output_two_b;
        end
    end

    // ============================================================
    // Fault, selector match and power indicators
    // Selector mismatch lights both fault indicators, it affects both axes
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_led_fault_a              <= 1'b0;
            o_led_fault_b              <= 1'b0;
            o_selector_match_indicator <= 1'b0;
            o_led_power                <= 1'b0;
        end else if (i_ce) begin
            o_led_fault_a              <= sel_err_q | err_a;
            o_led_fault_b              <= sel_err_q | err_b;
            o_selector_match_indicator <= cap_done_q
                                          && (sel1_q == sel2_q);
            o_led_power                <= 1'b1;
        end
    end
endmodule // ssd_top

// ===== ssd_consts.svh
// Named constants for the dual axis safe stop delay unit.
// Assumes a single 25 MHz system clock; included by bare name.
`ifndef SSD_CONSTS_SVH
`define SSD_CONSTS_SVH

// ============================================================
// Clock and time base
`define SSD_CLK_KHZ        25000      // System clock in kHz (40 ns period)
`define SSD_TICK_MS        100        // Time base tick period in ms
`define SSD_ERR_TICKS      2          // Persistence before an input error

// ============================================================
// Delay figures in ms
`define SSD_DLY_0_MS       0
`define SSD_DLY_1P4_MS     1400
`define SSD_DLY_2P8_MS     2800
`define SSD_DLY_5P6_MS     5600
`define SSD_DLY_9P8_MS     9800
`define SSD_DLY_30P8_MS    30800

// ============================================================
// Selector capture and widths
`define SSD_SEL_W          4          // Selector code width
`define SSD_DLY_W          16         // Delay width in ticks
`define SSD_SETTLE_CYC     2'h3       // Cycles before selectors are taken
`define SSD_TICK_W         32         // Tick prescaler width

`endif

// ===== ssd_pkg.sv
// Types shared by the safe stop delay unit.
// Assumes ssd_consts.svh is available on the include path.
`include "ssd_consts.svh"

package ssd_pkg;
    // ============================================================
    // Axis state, one-hot
    typedef enum logic [2:0] {
        SSD_ST_RUN = 3'b001,  // Outputs closed, axis may drive
        SSD_ST_DLY = 3'b010,  // Shut-off requested, delay running
        SSD_ST_STO = 3'b100   // Outputs open, torque off
    } ssd_state_e;

    typedef logic [`SSD_DLY_W-1:0] ssd_dly_t;
    typedef logic [`SSD_SEL_W-1:0] ssd_sel_t;
endpackage

// ===== ssd_axis.sv
// One axis of the safe stop delay: delay timer, STO state, input checks.
// Assumes synchronised inputs and a one-cycle time base tick from the top.
`timescale 1ns/100ps
`include "ssd_consts.svh"

module ssd_axis #(
    parameter logic [3:0] P_ERR_TICKS = 4'(`SSD_ERR_TICKS)
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_ce,
    input  wire logic             i_tick,
    input  wire ssd_pkg::ssd_dly_t i_dly,
    input  wire logic             i_ch1,
    input  wire logic             i_ch2,
    input  wire logic             i_rel,
    input  wire logic             i_tof,
    input  wire logic             i_hold,
    output ssd_pkg::ssd_state_e   o_state,
    output logic                  o_err
);
    import ssd_pkg::*;

    ssd_state_e state_q;
    ssd_dly_t   cnt_q;
    logic       rel_prev_q;
    logic [3:0] disc_q;
    logic [3:0] tofe_q;
    logic       shut;
    logic       rel_fall;
    logic       sto;

    // ============================================================
    // Request and release decode
    // Either open channel counts as a request: the safe reading of a split
    assign shut     = ~i_ch1 | ~i_ch2;
    assign rel_fall = rel_prev_q & ~i_rel;  // Connected to released
    assign sto      = state_q[2];

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rel_prev_q <= 1'b0;
        end else if (i_ce) begin
            rel_prev_q <= i_rel;
        end
    end

    // ============================================================
    // Axis state machine; starts in STO so power-up needs a release
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_q <= SSD_ST_STO;
            cnt_q   <= '0;
        end else if (i_ce) begin
            case (state_q)
                SSD_ST_RUN: begin
                    if (i_hold) begin
                        state_q <= SSD_ST_STO;
                    end else if (shut) begin
                        state_q <= SSD_ST_DLY;  // Timing starts
                        cnt_q   <= '0;
                    end
                end
                SSD_ST_DLY: begin
                    // A started stop runs out even if the request drops
                    if (i_hold) begin
                        state_q <= SSD_ST_STO;
                    end else if (cnt_q >= i_dly) begin
                        state_q <= SSD_ST_STO;  // Delay expired; only i_hold ends it sooner
                    end else if (i_tick) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                SSD_ST_STO: begin
                    if (rel_fall && !shut && !i_hold) begin
                        state_q <= SSD_ST_RUN;
                    end
                end
                default: state_q <= SSD_ST_STO;
            endcase
        end
    end

    // ============================================================
    // Channel discrepancy and feedback mismatch, counted in ticks
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            disc_q <= 4'h0;
            tofe_q <= 4'h0;
        end else if (i_ce) begin
            if (i_ch1 == i_ch2) begin
                disc_q <= 4'h0;
            end else if (i_tick && disc_q != P_ERR_TICKS) begin
                disc_q <= disc_q + 4'h1;
            end
            // Amplifier gets a grace window to follow the outputs
            if (i_tof == sto) begin
                tofe_q <= 4'h0;
            end else if (i_tick && tofe_q != P_ERR_TICKS) begin
                tofe_q <= tofe_q + 4'h1;
            end
        end
    end

    // Sticky error, cleared only by power-up reset
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_err <= 1'b0;
        end else if (i_ce) begin
            if (disc_q == P_ERR_TICKS || tofe_q == P_ERR_TICKS
                || (rel_fall && shut)) begin
                o_err <= 1'b1;
            end
        end
    end

    assign o_state = state_q;
endmodule // ssd_axis

// ===== ssd_asserts.sv
// Checker for the safe stop delay top, bound from the testbench.
// Assumes the top's port names; one clock, synchronous active low reset.
`timescale 1ns/100ps
module ssd_asserts (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_shutoff_channel_one_a,
    input wire logic i_shutoff_release_input_a,
    input wire logic o_safety_output_one_a,
    input wire logic o_safety_output_two_a,
    input wire logic o_safety_output_one_b,
    input wire logic o_safety_output_two_b,
    input wire logic o_led_sto_a,
    input wire logic o_led_fault_a,
    input wire logic o_led_fault_b,
    input wire logic o_led_channel_one_a,
    input wire logic o_selector_match_indicator,
    input wire logic o_led_power
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ==========================================================
    // Sequences: inputs held still long enough to pass the sync
    sequence rel_still_s;
        $stable(i_shutoff_release_input_a) [*8];
    endsequence
    sequence ch_still_s;
        ($stable(i_shutoff_channel_one_a) && o_led_power) [*5];
    endsequence
    // ==========================================================
    // Output and indicator relations
    AST_PAIR_A:
    assert property (o_safety_output_one_a == o_safety_output_two_a)
        else $error("axis a safety outputs differ");
    AST_PAIR_B:
    assert property (o_safety_output_one_b == o_safety_output_two_b)
        else $error("axis b safety outputs differ");
    AST_STO_LED_A:
    assert property ($changed(o_safety_output_one_a)
        |-> o_led_sto_a != o_safety_output_one_a)
        else $error("axis a sto indicator wrong");
    AST_CH_LED_A:
    assert property (ch_still_s
        |-> o_led_channel_one_a != i_shutoff_channel_one_a)
        else $error("axis a channel indicator wrong");
    // Only an edge of the release input may lift torque off
    AST_REL_STATIC_A:
    assert property ((rel_still_s ##0 !o_safety_output_one_a)
        |=> !o_safety_output_one_a)
        else $error("axis a released on a static level");
    AST_FAULT_HOLD_A:
    assert property (o_led_fault_a |=> o_led_fault_a)
        else $error("axis a fault cleared without reset");
    AST_FAULT_STO:
    assert property ((o_led_fault_a || o_led_fault_b) |-> ##[0:2]
        !(o_safety_output_one_a || o_safety_output_one_b))
        else $error("fault did not force torque off");
    // Capture is long over eight cycles after power shows
    AST_MISMATCH:
    assert property ((o_led_power [*8] ##1
        (o_led_power && !o_selector_match_indicator))
        |-> o_led_fault_a && o_led_fault_b)
        else $error("selector mismatch without fault");
endmodule // ssd_asserts

// ===== ssd_partner.sv
// Safety switches and amplifier feedback for one axis.
// Assumes the testbench commands request, release and fault cases.
`timescale 1ns/100ps
module ssd_partner (
    input  wire logic i_clk,
    input  wire logic i_req,
    input  wire logic i_split,
    input  wire logic i_rel,
    input  wire logic i_bad,
    input  wire logic i_out,
    output logic      o_ch1,
    output logic      o_ch2,
    output logic      o_rel,
    output logic      o_tof
);
    // Both contacts open together on a request; split breaks that
    assign o_ch1 = !i_req;
    assign o_ch2 = !(i_req ^ i_split);
    assign o_rel = i_rel;
    // Feedback follows the outputs a cycle late; bad inverts it
    always @(posedge i_clk) begin
        o_tof <= i_bad ? i_out : !i_out;
    end
endmodule // ssd_partner

// ===== dual_axis_safe_stop_delay_tb.sv
// Testbench for the safe stop delay top with switch/amplifier models.
// Assumes a shortened tick of TICK clocks; delays are in ticks.
`timescale 1ns/100ps
module dual_axis_safe_stop_delay_tb;
    localparam int TICK = 10;
    logic clk = 0, rstn = 0;
    ssd_pkg::ssd_sel_t sel1 = '0, sel2 = '0;
    logic [1:0] req = 0, rel = 0, split = 0, bad = 0;
    wire [1:0] so1, so2, lrel, lch1, lsto, lout1, lfault, ch1, ch2, relp, torque_off_feedback;
    wire [1:0] lch2, lout2;
    wire match, pwr;
    logic [1:0] win;
    int n_fail = 0, n_compared = 0, n, c, ax, cnt [2];
    // Delay in ticks per code, A row then B row
    int dly [2][16] = '{'{0,0,0,0,0,14,14,14,28,28,28,56,56,98,98,308},
        '{0,14,28,98,308,28,98,308,28,98,308,98,308,98,308,308}};
    always #20 clk = ~clk;
    ssd_top #(.P_TICK_CYC(TICK)) u_ssd_top (.i_clk(clk), .i_rstn(rstn),
        .i_ce(1'b1), .i_delay_selector_first(sel1),
        .i_delay_selector_second(sel2),
        .i_shutoff_channel_one_a(ch1[0]), .i_shutoff_channel_two_a(ch2[0]),
        .i_shutoff_release_input_a(relp[0]), .i_torque_off_feedback_a(torque_off_feedback[0]),
        .i_shutoff_channel_one_b(ch1[1]), .i_shutoff_channel_two_b(ch2[1]),
        .i_shutoff_release_input_b(relp[1]), .i_torque_off_feedback_b(torque_off_feedback[1]),
        .o_safety_output_one_a(so1[0]), .o_safety_output_two_a(so2[0]),
        .o_safety_output_one_b(so1[1]), .o_safety_output_two_b(so2[1]),
        .o_led_release_a(lrel[0]), .o_led_channel_one_a(lch1[0]),
        .o_led_channel_two_a(lch2[0]), .o_led_sto_a(lsto[0]),
        .o_led_out_one_a(lout1[0]), .o_led_out_two_a(lout2[0]),
        .o_led_fault_a(lfault[0]), .o_led_release_b(lrel[1]),
        .o_led_channel_one_b(lch1[1]), .o_led_channel_two_b(lch2[1]),
        .o_led_sto_b(lsto[1]), .o_led_out_one_b(lout1[1]),
        .o_led_out_two_b(lout2[1]), .o_led_fault_b(lfault[1]),
        .o_selector_match_indicator(match), .o_led_power(pwr));
    for (genvar g = 0; g < 2; g++) begin : g_ax
        ssd_partner u_ssd_partner (.i_clk(clk), .i_req(req[g]),
            .i_split(split[g]), .i_rel(rel[g]), .i_bad(bad[g]),
            .i_out(so1[g]), .o_ch1(ch1[g]), .o_ch2(ch2[g]),
            .o_rel(relp[g]), .o_tof(torque_off_feedback[g]));
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Power-up reset with given selector codes, then wait past capture
    task automatic power_up(input ssd_pkg::ssd_sel_t s1, s2);
        @(negedge clk);
        rstn = 0; sel1 = s1; sel2 = s2;
        req = 0; rel = 0; split = 0; bad = 0;
        repeat (4) @(negedge clk);
        rstn = 1;
        repeat (12) @(negedge clk);
    endtask
    // Release contact closed, then opened; only the opening counts
    task automatic free_axis(input int a, input logic exp);
        rel[a] = 1'b1;
        repeat (8) @(negedge clk);
        check(so1[a], 1'b0);
        check(lrel[a], 1'b1);
        rel[a] = 1'b0;
        repeat (8) @(negedge clk);
        check(so1[a], exp);
        check(lrel[a], 1'b0);
        check(lsto[a], !exp);
        check(lout1[a], !exp);
    endtask
    // ==========================================================
    // Every selector code: delay per axis and indicators in STO
    initial begin
        for (c = 0; c < 16; c++) begin
            power_up(4'(c), 4'(c));
            check(match, 1'b1);
            check(pwr, 1'b1);
            sel1 = 4'(~c);
            sel2 = 4'(c + 3);
            free_axis(0, 1'b1);
            free_axis(1, 1'b1);
            req = 2'b11;
            n = 0;
            cnt = '{0, 0};
            while (so1 !== 2'b00 && n < 3200) begin
                @(negedge clk);
                n++;
                for (ax = 0; ax < 2; ax++) if (so1[ax]) cnt[ax] = n;
            end
            for (ax = 0; ax < 2; ax++)
                win[ax] = cnt[ax] >= dly[ax][c] * TICK - TICK
                    && cnt[ax] <= dly[ax][c] * TICK + 16;
            check(win, 2'b11);
            repeat (2) @(negedge clk);
            check(lsto, 2'b11);
            check(lout1, 2'b11);
            check(lout2, 2'b11);
            check(lch1, 2'b11);
            check(lch2, 2'b11);
            check(lfault, 2'b00);
            check(match, 1'b1);
        end
        // Selector mismatch: dark match light, both faults, no release
        power_up(4'h3, 4'h5);
        check(match, 1'b0);
        check(lfault, 2'b11);
        free_axis(0, 1'b0);
        // Wrong amplifier feedback on A stops both axes for good
        power_up(4'h0, 4'h0);
        free_axis(0, 1'b1);
        free_axis(1, 1'b1);
        bad[0] = 1'b1;
        repeat (4 * TICK) @(negedge clk);
        check(lfault, 2'b01);
        check(so1, 2'b00);
        free_axis(1, 1'b0);
        // Channels of B disagree
        power_up(4'h0, 4'h0);
        free_axis(1, 1'b1);
        split[1] = 1'b1;
        repeat (4 * TICK) @(negedge clk);
        check(lfault[1], 1'b1);
        // Release edge while a channel is still open
        power_up(4'h0, 4'h0);
        free_axis(0, 1'b1);
        req[0] = 1'b1;
        repeat (20) @(negedge clk);
        free_axis(0, 1'b0);
        check(lfault[0], 1'b1);
        end_of_test();
    end
    // Watchdog well beyond the longest expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule // dual_axis_safe_stop_delay_tb
bind ssd_top ssd_asserts u_ssd_asserts (.*);
